// ### core/rsf_framer.sv
// raw serial frame send and receive logic for two ports, AXI4-Lite registers
// Operation
// - send fetches N bytes from source words
// - optional start byte prepended to frame
// - optional CR+LF or end byte appended
// - codes extra to N, N at most 256
// - byte order from control bit 0, bits 3..1 must be zero
// - line control drives lines from bits 15/14
// - line control 1-3 ignores the peer ready line
// - frame holds at most 259 bytes
// - zero byte count sends nothing
// - fault on bad mode, control or count
// - count mode completes at configured count
// - end mode completes on code or 256
// - built-in port overflows after completion
// - option port end mode overflow rules
// - option port overflows at 257 without code
// - receive counter 0 to 256 per port
// - configurable gap after each frame
// - receive read clears complete and counter
// - restart clears complete and counter
`timescale 1ns/10ps
`include "rsf_cfg.svh"
module rsf_framer (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite slave
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  output      logic [1:0]             s_axi_bresp,
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // byte streams, index 0 built-in port, 1 option port
  output      rsf_pkg::rsf_byte_t [1:0] tx_out,
  input  wire logic [1:0]             tx_ready,
  input  wire rsf_pkg::rsf_byte_t [1:0] rx_in,
  // modem lines
  output      logic [1:0]             request_to_send_line,
  output      logic [1:0]             host_ready_line,
  input  wire logic [1:0]             peer_ready_line
);
  rsf_pkg::rsf_state_t s_ff;
  rsf_pkg::rsf_state_t nxt_s;
  logic [15:0] txm [128];
  logic [7:0]  rxm [2][256];
  logic        do_wr;
  logic        cmd_go;
  logic        rxc_go;
  logic        txm_we;
  logic [1:0]  rx_we;
  logic [1:0][7:0] rx_wa;
  logic [15:0] cur_w;
  logic [7:0]  cur_b;
  logic [31:0] flg;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i]) o[i*8 +: 8] = v[i*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic raw_on(input rsf_pkg::rsf_state_t s, input logic p);
    return s.cfg[p][`RSF_F_RAW];
  endfunction

  function automatic logic tx_rdy(input rsf_pkg::rsf_state_t s, input logic p,
                                  input logic pr);
    return (s.st == rsf_pkg::ST_IDLE) && pr && raw_on(s, p);
  endfunction

  // ----------------------------------------
  // flag word and current send byte
  // ----------------------------------------
  always_comb begin
    flg = 32'h0000_0000;
    for (int p = 0; p < 2; p++) begin
      flg[p*`RSF_B_P1 + `RSF_B_RDY]  = tx_rdy(s_ff, p[0], peer_ready_line[p]);
      flg[p*`RSF_B_P1 + `RSF_B_DONE] = s_ff.rx[p].done;
      flg[p*`RSF_B_P1 + `RSF_B_OVF]  = s_ff.rx[p].ovf;
    end
  end

  always_comb begin
    cur_w = txm[s_ff.idx[7:1]];
    // order 1 sends the lower byte of each word first
    cur_b = (s_ff.idx[0] ^ s_ff.cmd[`RSF_F_ORD]) ? cur_w[7:0] : cur_w[15:8];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] c;
    logic [8:0]  nn;
    logic        pt;
    logic        bad;
    logic [1:0]  em;
    logic [8:0]  lim;
    rsf_pkg::rsf_rx_t r;
    c = s_ff.wd[15:0];
    nn = s_ff.wd[`RSF_F_N +: 9];
    pt = c[`RSF_F_PRT];
    bad = 1'b0;
    em = s_ff.cfg[s_ff.port][`RSF_F_EM +: 2];
    lim = 9'h000;
    r = '0;
    nxt_s = s_ff;
    txm_we = 1'b0;
    rx_we = 2'b00;
    rx_wa = '0;
    do_wr = s_ff.awh && s_ff.wh && !s_ff.bv;
    cmd_go = do_wr && (s_ff.awa == `RSF_A_CMD);
    rxc_go = do_wr && (s_ff.awa == `RSF_A_RXC);
    // write channel
    if (s_axi_awvalid && s_ff.awr) begin
      nxt_s.awh = 1'b1;
      nxt_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wr) begin
      nxt_s.wh = 1'b1;
      nxt_s.wd = s_axi_wdata;
      nxt_s.ws = s_axi_wstrb;
    end
    if (s_ff.bv && s_axi_bready) nxt_s.bv = 1'b0;
    if (do_wr) begin
      nxt_s.awh = 1'b0;
      nxt_s.wh = 1'b0;
      nxt_s.bv = 1'b1;
      nxt_s.br = `RSF_OKAY;
      case (s_ff.awa)
        `RSF_A_CMD, `RSF_A_RXC: ;
        `RSF_A_CFG0: nxt_s.cfg[0] = merge(s_ff.cfg[0], s_ff.wd, s_ff.ws);
        `RSF_A_CFG1: nxt_s.cfg[1] = merge(s_ff.cfg[1], s_ff.wd, s_ff.ws);
        `RSF_A_DLY: nxt_s.dly = 16'(merge({16'h0000, s_ff.dly}, s_ff.wd, s_ff.ws));
        default: begin
          if (s_ff.awa[11:9] == `RSF_W_TXM) txm_we = 1'b1;
          else nxt_s.br = `RSF_SLVERR;
        end
      endcase
    end
    nxt_s.awr = !nxt_s.awh && !nxt_s.bv;
    nxt_s.wr = !nxt_s.wh && !nxt_s.bv;
    // send command
    if (cmd_go) begin
      bad = (c[15:9] != 7'h00) || (c[3:1] != 3'h0) || (c[7:6] != 2'h0);
      nxt_s.fault = !raw_on(s_ff, pt) || bad || (nn > `RSF_MAXN);
      if (!nxt_s.fault && (c[`RSF_F_LC +: 2] != 2'h0)) begin
        case (c[`RSF_F_LC +: 2])
          2'h1: nxt_s.rts[pt] = txm[0][15];
          2'h2: nxt_s.hrdy[pt] = txm[0][15];
          default: begin
            nxt_s.rts[pt] = txm[0][15];
            nxt_s.hrdy[pt] = txm[0][14];
          end
        endcase
      end
      if (!nxt_s.fault && (nn != 9'h000) && (s_ff.st == rsf_pkg::ST_IDLE)
          && (peer_ready_line[pt] || (c[`RSF_F_LC +: 2] != 2'h0))) begin
        nxt_s.cmd = c;
        nxt_s.n = nn;
        nxt_s.port = pt;
        nxt_s.idx = 9'h000;
        nxt_s.st = s_ff.cfg[pt][`RSF_F_SE] ? rsf_pkg::ST_START : rsf_pkg::ST_DATA;
      end
    end
    // frame sender
    case (s_ff.st)
      rsf_pkg::ST_IDLE: ;
      rsf_pkg::ST_START, rsf_pkg::ST_DATA, rsf_pkg::ST_END1, rsf_pkg::ST_END2: begin
        if (!s_ff.tx[s_ff.port].vld) begin
          nxt_s.tx[s_ff.port].vld = 1'b1;
          case (s_ff.st)
            rsf_pkg::ST_START: nxt_s.tx[s_ff.port].dat = s_ff.cfg[s_ff.port][`RSF_F_SB +: 8];
            rsf_pkg::ST_DATA: nxt_s.tx[s_ff.port].dat = cur_b;
            rsf_pkg::ST_END1: nxt_s.tx[s_ff.port].dat = (em == `RSF_EM_CRLF) ? `RSF_CR :
                                s_ff.cfg[s_ff.port][`RSF_F_EB +: 8];
            default: nxt_s.tx[s_ff.port].dat = `RSF_LF;
          endcase
        end else if (tx_ready[s_ff.port]) begin
          nxt_s.tx[s_ff.port].vld = 1'b0;
          nxt_s.gap = 16'h0000;
          nxt_s.dtick = 4'h0;
          case (s_ff.st)
            rsf_pkg::ST_START: nxt_s.st = rsf_pkg::ST_DATA;
            rsf_pkg::ST_DATA: begin
              nxt_s.idx = s_ff.idx + 9'h001;
              if (nxt_s.idx == s_ff.n) begin
                nxt_s.st = (em != `RSF_EM_NONE) ? rsf_pkg::ST_END1 : rsf_pkg::ST_GAP;
              end
            end
            rsf_pkg::ST_END1: begin
              nxt_s.st = (em == `RSF_EM_CRLF) ? rsf_pkg::ST_END2 : rsf_pkg::ST_GAP;
            end
            default: nxt_s.st = rsf_pkg::ST_GAP;
          endcase
        end
      end
      rsf_pkg::ST_GAP: begin
        // spacing in whole microseconds before the next frame
        if (s_ff.gap >= s_ff.dly) nxt_s.st = rsf_pkg::ST_IDLE;
        else if (s_ff.dtick == 4'(`RSF_DLY_CYC - 1)) begin
          nxt_s.dtick = 4'h0;
          nxt_s.gap = s_ff.gap + 16'h0001;
        end else nxt_s.dtick = s_ff.dtick + 4'h1;
      end
      default: nxt_s.st = rsf_pkg::ST_IDLE;
    endcase
    // receivers
    for (int p = 0; p < 2; p++) begin
      r = s_ff.rx[p];
      em = s_ff.cfg[p][`RSF_F_EM +: 2];
      lim = (em != `RSF_EM_NONE) ? `RSF_MAXN :
            (s_ff.cfg[p][`RSF_F_LEN +: 8] == 8'h00) ? `RSF_MAXN :
            {1'b0, s_ff.cfg[p][`RSF_F_LEN +: 8]};
      if (rxc_go && (s_ff.wd[p] || s_ff.wd[8+p])) begin
        r.done = 1'b0;
        r.cnt = 9'h000;
        r.got_end = 1'b0;
        r.prev_cr = 1'b0;
        if (s_ff.wd[8+p]) r.ovf = 1'b0;
      end
      // a byte in the clearing cycle lands on the cleared state
      if (rx_in[p].vld && raw_on(s_ff, p[0])) begin
        if (r.done) begin
          if ((p == 0) || (em == `RSF_EM_NONE) || !r.got_end) r.ovf = 1'b1;
        end else if ((em == `RSF_EM_BYTE) && (rx_in[p].dat == s_ff.cfg[p][`RSF_F_EB +: 8])) begin
          r.done = 1'b1;
          r.got_end = 1'b1;
        end else if ((em == `RSF_EM_CRLF) && r.prev_cr && (rx_in[p].dat == `RSF_LF)) begin
          r.done = 1'b1;
          r.got_end = 1'b1;
          r.cnt = r.cnt - 9'h001;
        end else begin
          rx_we[p] = 1'b1;
          rx_wa[p] = r.cnt[7:0];
          r.cnt = r.cnt + 9'h001;
          r.prev_cr = (rx_in[p].dat == `RSF_CR);
          if (r.cnt == lim) r.done = 1'b1;
        end
      end
      nxt_s.rx[p] = r;
    end
    // read channel
    if (s_ff.rv && s_axi_rready) nxt_s.rv = 1'b0;
    if (s_axi_arvalid && s_ff.arr) begin
      nxt_s.rv = 1'b1;
      nxt_s.rr = `RSF_OKAY;
      case (s_axi_araddr)
        `RSF_A_CMD: nxt_s.rd = {7'h00, s_ff.n, s_ff.cmd};
        `RSF_A_CFG0: nxt_s.rd = s_ff.cfg[0];
        `RSF_A_CFG1: nxt_s.rd = s_ff.cfg[1];
        `RSF_A_DLY: nxt_s.rd = {16'h0000, s_ff.dly};
        `RSF_A_STAT: nxt_s.rd = {30'h0, s_ff.fault, s_ff.st != rsf_pkg::ST_IDLE};
        `RSF_A_RXC: nxt_s.rd = 32'h0000_0000;
        12'(`RSF_I_FLG * 4): nxt_s.rd = flg;
        12'(`RSF_I_CNT0 * 4): nxt_s.rd = {23'h0, s_ff.rx[0].cnt};
        12'(`RSF_I_CNT1 * 4): nxt_s.rd = {23'h0, s_ff.rx[1].cnt};
        default: begin
          if (s_axi_araddr[11:9] == `RSF_W_TXM) begin
            nxt_s.rd = {16'h0000, txm[s_axi_araddr[8:2]]};
          end else if (s_axi_araddr[11:10] == `RSF_W_RXM) begin
            nxt_s.rd = {16'h0000, rxm[s_axi_araddr[9]][{s_axi_araddr[8:2], 1'b0}],
                        rxm[s_axi_araddr[9]][{s_axi_araddr[8:2], 1'b1}]};
          end else begin
            nxt_s.rd = 32'h0000_0000;
            nxt_s.rr = `RSF_SLVERR;
          end
        end
      endcase
    end
    nxt_s.arr = !nxt_s.rv;
  end

  // ----------------------------------------
  // registers and memories
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.awr <= 1'b1;
      s_ff.wr <= 1'b1;
      s_ff.arr <= 1'b1;
      s_ff.cfg <= {`RSF_RST_CFG, `RSF_RST_CFG};
      s_ff.dly <= `RSF_RST_DLY;
      s_ff.st <= rsf_pkg::ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (txm_we && s_ff.ws[0]) txm[s_ff.awa[8:2]][7:0] <= s_ff.wd[7:0];
    if (txm_we && s_ff.ws[1]) txm[s_ff.awa[8:2]][15:8] <= s_ff.wd[15:8];
    for (int p = 0; p < 2; p++) begin
      if (rx_we[p]) rxm[p][rx_wa[p]] <= rx_in[p].dat;
    end
  end

  assign s_axi_awready = s_ff.awr;
  assign s_axi_wready = s_ff.wr;
  assign s_axi_bvalid = s_ff.bv;
  assign s_axi_bresp = s_ff.br;
  assign s_axi_arready = s_ff.arr;
  assign s_axi_rvalid = s_ff.rv;
  assign s_axi_rdata = s_ff.rd;
  assign s_axi_rresp = s_ff.rr;
  assign tx_out = s_ff.tx;
  assign request_to_send_line = s_ff.rts;
  assign host_ready_line = s_ff.hrdy;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ZERO_NOSEND: assert property (
    cmd_go && s_ff.st == rsf_pkg::ST_IDLE && s_ff.wd[`RSF_F_N +: 9] == 9'h000
    |=> s_ff.st == rsf_pkg::ST_IDLE) else $error("zero count started a frame");
  AST_FAULT_N: assert property (
    cmd_go && s_ff.wd[`RSF_F_N +: 9] > `RSF_MAXN |=> s_ff.fault && s_ff.st != rsf_pkg::ST_START)
    else $error("oversize count not flagged");
  AST_START_BYTE: assert property (
    s_ff.st == rsf_pkg::ST_START && tx_out[s_ff.port].vld
    |-> tx_out[s_ff.port].dat == s_ff.cfg[s_ff.port][`RSF_F_SB +: 8])
    else $error("wrong start byte");
  AST_CRLF: assert property (
    s_ff.st == rsf_pkg::ST_END2 && tx_out[s_ff.port].vld |-> tx_out[s_ff.port].dat == `RSF_LF)
    else $error("line feed missing");
  AST_HOLD: assert property (
    tx_out[0].vld && !tx_ready[0] |=> tx_out[0].vld && $stable(tx_out[0].dat))
    else $error("send byte dropped before taken");
  AST_RXCNT: assert property (s_ff.rx[0].cnt <= `RSF_MAXN && s_ff.rx[1].cnt <= `RSF_MAXN)
    else $error("receive counter above limit");
  AST_READ_CLR: assert property (
    rxc_go && s_ff.wd[0] && !rx_in[0].vld |=> !s_ff.rx[0].done && s_ff.rx[0].cnt == 9'h000)
    else $error("receive read did not clear port");
  AST_OVF0: assert property (
    s_ff.rx[0].done && rx_in[0].vld && raw_on(s_ff, 1'b0) && !rxc_go |=> s_ff.rx[0].ovf)
    else $error("overflow not flagged");
  AST_RTS: assert property (
    cmd_go && !nxt_s.fault && s_ff.wd[`RSF_F_LC +: 2] == 2'h3
    |=> request_to_send_line[$past(s_ff.wd[`RSF_F_PRT])] == $past(txm[0][15]))
    else $error("line not driven from bit 15");
  AST_GAP: assert property (
    s_ff.st == rsf_pkg::ST_GAP && s_ff.gap < s_ff.dly |=> s_ff.st == rsf_pkg::ST_GAP)
    else $error("gap ended early");

  COV_CRLF_SEND: cover property (s_ff.st == rsf_pkg::ST_END2 && tx_ready[s_ff.port]);
  COV_RX_DONE: cover property (!s_ff.rx[1].done ##1 s_ff.rx[1].done);
  COV_OVF: cover property (!s_ff.rx[0].ovf ##1 s_ff.rx[0].ovf);
endmodule

// ### inc/rsf_cfg.svh
// offsets, field positions, reset values and timing counts of the raw serial framer
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
// ----------------------------------------
// register byte addresses and indices
// ----------------------------------------
`define RSF_A_CMD      12'h000
`define RSF_A_CFG0     12'h004
`define RSF_A_CFG1     12'h008
`define RSF_A_DLY      12'h00c
`define RSF_A_STAT     12'h010
`define RSF_A_RXC      12'h014
`define RSF_I_FLG      12'h188
`define RSF_I_CNT0     12'h189
`define RSF_I_CNT1     12'h18a
`define RSF_W_TXM      3'h2
`define RSF_W_RXM      2'h2
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSF_F_ORD      0
`define RSF_F_LC       4
`define RSF_F_PRT      8
`define RSF_F_N        16
`define RSF_F_SB       0
`define RSF_F_EB       8
`define RSF_F_EM       16
`define RSF_F_SE       18
`define RSF_F_RAW      19
`define RSF_F_LEN      24
`define RSF_B_RDY      5
`define RSF_B_DONE     6
`define RSF_B_OVF      7
`define RSF_B_P1       8
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RSF_RST_CFG    32'h0000_0000
`define RSF_RST_DLY    16'h0000
`define RSF_MAXN       9'h100
`define RSF_CR         8'h0d
`define RSF_LF         8'h0a
`define RSF_EM_NONE    2'h0
`define RSF_EM_CRLF    2'h1
`define RSF_EM_BYTE    2'h2
`define RSF_OKAY       2'h0
`define RSF_SLVERR     2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define RSF_CLK_NS     100
`define RSF_DLY_UNIT_NS 1000
`define RSF_DLY_CYC    (`RSF_DLY_UNIT_NS / `RSF_CLK_NS)
`endif

// ### inc/rsf_pkg.sv
// types of the raw serial framer
package rsf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_END1  = 3'h3,
    ST_END2  = 3'h4,
    ST_GAP   = 3'h5
  } rsf_st_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] dat;
  } rsf_byte_t;

  typedef struct packed {
    logic       done;
    logic       ovf;
    logic       got_end;
    logic       prev_cr;
    logic [8:0] cnt;
  } rsf_rx_t;

  typedef struct packed {
    logic            awh;
    logic            wh;
    logic [11:0]     awa;
    logic [31:0]     wd;
    logic [3:0]      ws;
    logic            awr;
    logic            wr;
    logic            bv;
    logic [1:0]      br;
    logic            arr;
    logic            rv;
    logic [31:0]     rd;
    logic [1:0]      rr;
    logic [15:0]     cmd;
    logic [8:0]      n;
    logic [1:0][31:0] cfg;
    logic [15:0]     dly;
    logic            fault;
    rsf_st_t         st;
    logic [8:0]      idx;
    logic            port;
    logic [15:0]     gap;
    logic [3:0]      dtick;
    rsf_byte_t [1:0] tx;
    logic [1:0]      rts;
    logic [1:0]      hrdy;
    rsf_rx_t [1:0]   rx;
  } rsf_state_t;
endpackage

// ### test/rsf_peer.sv
// far-side serial device model: byte sink with stalls, byte source, peer ready lines
`timescale 1ns/10ps
module rsf_peer (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // byte streams
  input  wire rsf_pkg::rsf_byte_t [1:0] tx_out,
  output      logic [1:0]               tx_ready,
  output      rsf_pkg::rsf_byte_t [1:0] rx_in,
  // modem lines
  output      logic [1:0]               peer_ready_line
);
  logic [7:0] got [2][$];
  int         slow;
  int         stall [2];

  initial begin
    tx_ready = 2'h0;
    rx_in = '0;
    peer_ready_line = 2'h3;
    slow = 0;
  end

  // ----------------------------------------
  // sink: take a byte after slow idle cycles
  // ----------------------------------------
  always @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn || tx_ready[p]) begin
        if (aresetn && tx_out[p].vld)
          got[p].push_back(tx_out[p].dat);
        tx_ready[p] <= 1'b0;
        stall[p] = 0;
      end else if (tx_out[p].vld) begin
        if (stall[p] >= slow)
          tx_ready[p] <= 1'b1;
        stall[p]++;
      end
    end
  end

  // ----------------------------------------
  // source: one-cycle strobe, data scrambled after
  // ----------------------------------------
  task automatic send_rx(input int p, input logic [7:0] d);
    @(posedge aclk);
    rx_in[p] <= '{vld: 1'b1, dat: d};
    @(posedge aclk);
    rx_in[p] <= '{vld: 1'b0, dat: ~d};
  endtask
endmodule

// ### test/rsf_framer_tb.sv
// self-checking bench of the raw serial framer
`timescale 1ns/10ps
`include "rsf_cfg.svh"
module rsf_framer_tb;
  logic                     aclk;
  logic                     aresetn;
  logic [11:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata;
  logic [3:0]               s_axi_wstrb;
  logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                     s_axi_rvalid, s_axi_rready;
  logic [1:0]               s_axi_bresp, s_axi_rresp;
  rsf_pkg::rsf_byte_t [1:0] tx_out, rx_in;
  logic [1:0]               tx_ready, request_to_send_line, host_ready_line, peer_ready_line;
  int                       fail_count;
  int                       tests_run;
  logic [31:0]              rd;
  logic [1:0]               rsp;
  localparam logic [11:0]   A_FLG = `RSF_I_FLG << 2;
  localparam logic [11:0]   A_CNT0 = `RSF_I_CNT0 << 2;
  localparam logic [11:0]   A_CNT1 = `RSF_I_CNT1 << 2;

  rsf_framer u_rsf_framer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_out(tx_out),
    .tx_ready(tx_ready), .rx_in(rx_in), .request_to_send_line(request_to_send_line),
    .host_ready_line(host_ready_line), .peer_ready_line(peer_ready_line));

  rsf_peer u_rsf_peer (.aclk(aclk), .aresetn(aresetn), .tx_out(tx_out), .tx_ready(tx_ready),
    .rx_in(rx_in), .peer_ready_line(peer_ready_line));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("Error %s expected answer seen none", what);
    complete_run();
  endtask

  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (k == 50) hang("write response");
  endtask

  task automatic rd_reg(input logic [11:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (k == 50) hang("read data");
  endtask

  // ----------------------------------------
  // send helpers
  // ----------------------------------------
  function automatic logic [15:0] pat(input int i);
    return {8'(i * 3 + 1), 8'(i) ^ 8'ha5};
  endfunction

  task automatic fill(input int words);
    for (int i = 0; i < words; i++) wr(12'h400 + 12'(4 * i), {16'h0, pat(i)});
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 400; k++) begin
      rd_reg(`RSF_A_STAT);
      if (rd[0] === 1'b0) break;
    end
    if (k == 400) hang("idle");
  endtask

  task automatic send(input logic [3:0] ord, lc, prt, input logic [8:0] n);
    wait_idle();
    wr(`RSF_A_CMD, {7'h0, n, 4'h0, prt, lc, ord});
  endtask

  task automatic chk_tx(input int p, input logic [7:0] e[$]);
    chk("frame length", e.size(), u_rsf_peer.got[p].size());
    if (e.size() == u_rsf_peer.got[p].size())
      foreach (e[i]) chk("frame byte", e[i], u_rsf_peer.got[p][i]);
    u_rsf_peer.got[p].delete();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_reg(A_FLG);
    chk("receive flags", 32'h0, rd & 32'h0000_c0c0);
    rd_reg(A_CNT0);
    chk("count port0", 32'h0, rd);
    rd_reg(12'hffc);
    chk("unmapped response", `RSF_SLVERR, rsp);
    wr(12'hffc, 32'h0);
    chk("unmapped write", `RSF_SLVERR, rsp);
    $display("test reset done");
  endtask

  task automatic t_frames();
    logic [7:0]  e [$];
    logic [15:0] w0, w1;
    int          k;
    w0 = pat(0);
    w1 = pat(1);
    wr(`RSF_A_CFG0, {12'h000, 1'b1, 1'b1, `RSF_EM_CRLF, 8'h00, 8'h7e});
    wr(`RSF_A_DLY, 32'h3);
    fill(2);
    u_rsf_peer.slow = 3;
    rd_reg(A_FLG);
    chk("send ready", 1'b1, rd[5]);
    send(4'h0, 4'h0, 4'h0, 9'h3);
    for (k = 0; k < 300 && u_rsf_peer.got[0].size() < 6; k++) @(posedge aclk);
    if (k == 300) hang("frame bytes");
    rd_reg(`RSF_A_STAT);
    chk("busy in gap", 1'b1, rd[0]);
    wait_idle();
    e = {8'h7e, w0[15:8], w0[7:0], w1[15:8], `RSF_CR, `RSF_LF};
    chk_tx(0, e);
    wr(`RSF_A_CFG1, {12'h000, 1'b1, 1'b0, `RSF_EM_BYTE, 8'hc3, 8'h00});
    send(4'h1, 4'h0, 4'h1, 9'h3);
    wait_idle();
    e = {w0[7:0], w0[15:8], w1[7:0], 8'hc3};
    chk_tx(1, e);
    u_rsf_peer.slow = 0;
    fill(128);
    send(4'h0, 4'h0, 4'h0, 9'h100);
    wait_idle();
    e = {8'h7e};
    for (int i = 0; i < 128; i++) begin
      w0 = pat(i);
      e = {e, w0[15:8], w0[7:0]};
    end
    e = {e, `RSF_CR, `RSF_LF};
    chk_tx(0, e);
    $display("test frames done");
  endtask

  task automatic t_fault();
    logic [31:0] c [6] = '{32'h0000_0000, 32'h0101_0000, 32'h0001_1000,
                           32'h0001_0200, 32'h0001_0002, 32'h0001_0100};
    logic        f [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    wr(`RSF_A_CFG1, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wait_idle();
      wr(`RSF_A_CMD, c[i]);
      rd_reg(`RSF_A_STAT);
      chk("fault flag", f[i], rd[1]);
    end
    wait_idle();
    chk("bytes port0", 32'h0, u_rsf_peer.got[0].size());
    chk("bytes port1", 32'h0, u_rsf_peer.got[1].size());
    $display("test faults done");
  endtask

  task automatic t_lines();
    u_rsf_peer.peer_ready_line <= 2'h0;
    wr(12'h400, 32'h0000_4000);
    send(4'h0, 4'h0, 4'h0, 9'h1);
    wait_idle();
    chk("bytes without ready", 32'h0, u_rsf_peer.got[0].size());
    send(4'h0, 4'h3, 4'h0, 9'h1);
    wait_idle();
    chk("send line", 1'b0, request_to_send_line[0]);
    chk("host line", 1'b1, host_ready_line[0]);
    chk("bytes bypass", 32'h4, u_rsf_peer.got[0].size());
    wr(12'h400, 32'h0000_8000);
    send(4'h0, 4'h1, 4'h0, 9'h1);
    wait_idle();
    chk("send line", 1'b1, request_to_send_line[0]);
    wr(12'h400, 32'h0000_0000);
    send(4'h0, 4'h2, 4'h0, 9'h1);
    wait_idle();
    chk("host line", 1'b0, host_ready_line[0]);
    u_rsf_peer.peer_ready_line <= 2'h3;
    u_rsf_peer.got[0].delete();
    $display("test lines done");
  endtask

  task automatic t_rx();
    wr(`RSF_A_CFG0, {8'h03, 4'h0, 1'b1, 1'b0, `RSF_EM_NONE, 16'h0});
    send(4'h0, 4'h0, 4'h0, 9'h1);
    wait_idle();
    chk("bytes no codes", 32'h1, u_rsf_peer.got[0].size());
    wr(`RSF_A_RXC, 32'h100);
    u_rsf_peer.send_rx(0, 8'h11);
    u_rsf_peer.send_rx(0, 8'h22);
    u_rsf_peer.send_rx(0, 8'h33);
    rd_reg(A_FLG);
    chk("flags port0", 2'b01, rd[7:6]);
    rd_reg(A_CNT0);
    chk("count port0", 32'h3, rd);
    rd_reg(12'h800);
    chk("receive word", 32'h0000_1122, rd);
    u_rsf_peer.send_rx(0, 8'h44);
    rd_reg(A_FLG);
    chk("flags port0", 2'b11, rd[7:6]);
    wr(`RSF_A_RXC, 32'h1);
    rd_reg(A_FLG);
    chk("flags port0", 2'b10, rd[7:6]);
    rd_reg(A_CNT0);
    chk("count port0", 32'h0, rd);
    wr(`RSF_A_CFG0, {12'h000, 1'b1, 1'b0, `RSF_EM_BYTE, 8'h55, 8'h00});
    wr(`RSF_A_RXC, 32'h100);
    u_rsf_peer.send_rx(0, 8'h10);
    u_rsf_peer.send_rx(0, 8'h55);
    rd_reg(A_FLG);
    chk("flags port0", 2'b01, rd[7:6]);
    rd_reg(A_CNT0);
    chk("count port0", 32'h1, rd);
    u_rsf_peer.send_rx(0, 8'h20);
    rd_reg(A_FLG);
    chk("flags port0", 2'b11, rd[7:6]);
    wr(`RSF_A_RXC, 32'h100);
    rd_reg(A_FLG);
    chk("flags port0", 2'b00, rd[7:6]);
    rd_reg(A_CNT0);
    chk("count port0", 32'h0, rd);
    wr(`RSF_A_CFG1, {12'h000, 1'b1, 1'b0, `RSF_EM_BYTE, 8'h55, 8'h00});
    wr(`RSF_A_RXC, 32'h200);
    for (int i = 0; i < 256; i++) u_rsf_peer.send_rx(1, 8'h01);
    rd_reg(A_FLG);
    chk("flags port1", 2'b01, rd[15:14]);
    rd_reg(A_CNT1);
    chk("count port1", 32'h100, rd);
    u_rsf_peer.send_rx(1, 8'h02);
    rd_reg(A_FLG);
    chk("flags port1", 2'b11, rd[15:14]);
    $display("test receive done");
  endtask

  // ----------------------------------------
  // clock, reset and sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_frames();
    t_fault();
    t_lines();
    t_rx();
    complete_run();
  end
endmodule
